// ---- apwp_cfg.svh ----
`ifndef APWP_CFG_SVH
`define APWP_CFG_SVH

`define APWP_CLK_MHZ 25
`define APWP_STROBE_NS 80
`define APWP_STROBE_CYC ((`APWP_STROBE_NS * `APWP_CLK_MHZ + 999) / 1000)
`define APWP_SETUP_NS 40
`define APWP_SETUP_CYC ((`APWP_SETUP_NS * `APWP_CLK_MHZ + 999) / 1000)
`define APWP_HOLD_NS 40
`define APWP_HOLD_CYC ((`APWP_HOLD_NS * `APWP_CLK_MHZ + 999) / 1000)
`define APWP_RECOVERY_WORD 16'h0002
`define APWP_BYTE_W 8
`define APWP_WORD_W 16
`define APWP_RESULT_W 12

`endif

// ---- apwp_cycle_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface apwp_cycle_if;
    logic start;
    logic isRead;
    logic done;
    logic [3:0] waitStates;
    modport seq (input start, input isRead, input waitStates, output done);
    modport ctl (output start, output isRead, output waitStates, input done);
endinterface
`default_nettype wire

// ---- apwp_cycle_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "apwp_cfg.svh"
module apwp_cycle_seq
    import apwp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Cycle request
    apwp_cycle_if.seq cyc,
    // Strobes and data drive phase
    output logic strobeActive,
    output logic dataDrive,
    output logic sampleRead
);
    localparam int STROBE_CYC = `APWP_STROBE_CYC;
    localparam int SETUP_CYC = `APWP_SETUP_CYC;
    localparam int HOLD_CYC = `APWP_HOLD_CYC;
    if (STROBE_CYC < 1 || SETUP_CYC < 1 || HOLD_CYC < 1 || STROBE_CYC > 200) begin : gBadTiming
        $error("apwp_cycle_seq: timing counts out of range");
    end

    apwp_phase_type phase_ff;
    logic isRead_ff;
    logic [7:0] cnt_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_ff <= APWP_IDLE_ST;
            cnt_ff <= 8'h00;
            isRead_ff <= 1'b0;
        end else begin
            case (phase_ff)
                APWP_IDLE_ST: begin
                    if (cyc.start) begin
                        phase_ff <= APWP_SETUP_ST;
                        isRead_ff <= cyc.isRead;
                        cnt_ff <= 8'(SETUP_CYC - 1);
                    end
                end
                APWP_SETUP_ST: begin
                    if (cnt_ff == 8'h00) begin
                        phase_ff <= APWP_STROBE_ST;
                        // Wait states stretch the active strobe
                        cnt_ff <= 8'(STROBE_CYC - 1) + {4'h0, cyc.waitStates};
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                APWP_STROBE_ST: begin
                    if (cnt_ff == 8'h00) begin
                        phase_ff <= APWP_HOLD_ST;
                        cnt_ff <= 8'(HOLD_CYC - 1);
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                APWP_HOLD_ST: begin
                    if (cnt_ff == 8'h00) begin
                        phase_ff <= APWP_IDLE_ST;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                default: phase_ff <= APWP_IDLE_ST;
            endcase
        end
    end

    assign strobeActive = (phase_ff == APWP_STROBE_ST);
    // Write data held across setup, strobe and hold around the rising edge
    assign dataDrive = !isRead_ff && (phase_ff != APWP_IDLE_ST);
    // Read data taken on the last strobe cycle, before the strobe rises
    assign sampleRead = isRead_ff && strobeActive && (cnt_ff == 8'h00);
    assign cyc.done = (phase_ff == APWP_HOLD_ST) && (cnt_ff == 8'h00);
endmodule
`default_nettype wire

// ---- apwp_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module apwp_dev_model
    import apwp_pkg::*;
(
    // Device pins
    input wire logic csN,
    input wire logic wrN,
    input wire logic rdN,
    input wire logic wordByteSel,
    input wire logic [15:0] bus,
    output logic [15:0] devOut,
    output logic [15:0] devOe,
    // Model state
    input wire logic [11:0] convResult,
    output logic [15:0] lastWord
);
    logic wrGate;
    logic rdGate;
    logic testRegDefault;
    logic [7:0] lowByte = 8'h00;
    logic [3:0] hiReads = 4'h0;
    assign wrGate = !csN && !wrN;
    assign rdGate = !csN && !rdN;
    always @(negedge wrGate) begin
        if (wordByteSel) begin
            lastWord <= bus;
        end else if (!bus[8]) begin
            lowByte <= bus[7:0];
        end else begin
            lastWord <= {bus[7:0], lowByte};
        end
    end
    assign testRegDefault = (lastWord == 16'h0002);
    always @(negedge rdGate) begin
        if (!wordByteSel && bus[8]) begin
            hiReads <= hiReads + 4'h1;
        end
    end
    assign devOe = !rdGate ? 16'h0000 : (wordByteSel ? 16'hffff : 16'h00ff);
    assign devOut = wordByteSel ? {4'h0, convResult} :
        (bus[8] ? {12'h000, convResult[11:8]} : {8'h00, convResult[7:0]});
endmodule
`default_nettype wire

// ---- apwp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "apwp_cfg.svh"
module apwp_host
    import apwp_pkg::*;
#(
    parameter int WAIT_STATES = 0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Mode strap
    input wire logic wordMode,
    // Command port
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [1:0] cmdOp,
    input wire logic [15:0] cmdData,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic [11:0] rspResult,
    // Busy notification
    input wire logic busyPin,
    output logic busyFall,
    // Device pins
    output logic csN,
    output logic wrN,
    output logic rdN,
    output logic wordByteSel,
    output logic [15:0] dataLinesOut,
    output logic [15:0] dataLinesOe,
    input wire logic [15:0] dataLinesIn
);
    // Parameter and pin width checks at elaboration
    if (WAIT_STATES < 0 || WAIT_STATES > 15) begin : gBadWait
        $error("apwp_host: WAIT_STATES must be 0..15");
    end
    if (`APWP_WORD_W != 16 || `APWP_BYTE_W != 8 || `APWP_RESULT_W != 12) begin : gBadWidth
        $error("apwp_host: pin widths must be 16, 8 and 12");
    end

    typedef enum logic [2:0] {
        APWP_IDLE, APWP_LOW, APWP_HIGH, APWP_GAP, APWP_DONE
    } apwp_ctl_type;

    // Bus cycle sequencer and its handshake
    apwp_cycle_if cyc ();
    logic strobeActive;
    logic dataDrive;
    logic sampleRead;

    apwp_cycle_seq u_seq (
        .clk(clk),
        .arst_n(arst_n),
        .cyc(cyc),
        .strobeActive(strobeActive),
        .dataDrive(dataDrive),
        .sampleRead(sampleRead)
    );

    // Transfer state and captured command
    apwp_ctl_type state_ff;
    logic isRead_ff;
    logic byteMode_ff;
    logic highHalf_ff;
    logic issued_ff;
    logic [15:0] word_ff;
    logic [15:0] rdWord_ff;
    logic rspValid_ff;
    logic [15:0] rspData_ff;
    // Synchroniser stages for pins
    logic wordMode_s1_ff;
    logic wordMode_s2_ff;
    logic busy_s1_ff;
    logic busy_s2_ff;
    logic busy_d_ff;
    logic [15:0] din_s1_ff;
    logic [15:0] din_s2_ff;

    // Pin synchronisers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wordMode_s1_ff <= 1'b1;
            wordMode_s2_ff <= 1'b1;
            busy_s1_ff <= 1'b0;
            busy_s2_ff <= 1'b0;
            busy_d_ff <= 1'b0;
            din_s1_ff <= 16'h0000;
            din_s2_ff <= 16'h0000;
        end else begin
            wordMode_s1_ff <= wordMode;
            wordMode_s2_ff <= wordMode_s1_ff;
            busy_s1_ff <= busyPin;
            busy_s2_ff <= busy_s1_ff;
            busy_d_ff <= busy_s2_ff;
            din_s1_ff <= dataLinesIn;
            din_s2_ff <= din_s1_ff;
        end
    end

    // Busy falling edge signals end of conversion
    assign busyFall = busy_d_ff && !busy_s2_ff;

    // Transfer sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= APWP_IDLE;
            isRead_ff <= 1'b0;
            byteMode_ff <= 1'b0;
            highHalf_ff <= 1'b0;
            issued_ff <= 1'b0;
            word_ff <= 16'h0000;
        end else begin
            case (state_ff)
                APWP_IDLE: begin
                    if (cmdValid) begin
                        isRead_ff <= (cmdOp == APWP_OP_READ);
                        // Recovery sends the fixed word
                        word_ff <= (cmdOp == APWP_OP_RECOVER) ? `APWP_RECOVERY_WORD : cmdData;
                        byteMode_ff <= !wordMode_s2_ff;
                        highHalf_ff <= 1'b0;
                        issued_ff <= 1'b0;
                        state_ff <= APWP_LOW;
                    end
                end
                APWP_LOW, APWP_HIGH: begin
                    if (!issued_ff) begin
                        issued_ff <= 1'b1;
                    end else if (cyc.done) begin
                        issued_ff <= 1'b0;
                        if (byteMode_ff && !highHalf_ff) begin
                            state_ff <= APWP_GAP;
                        end else begin
                            state_ff <= APWP_DONE;
                        end
                    end
                end
                APWP_GAP: begin
                    highHalf_ff <= 1'b1;
                    state_ff <= APWP_HIGH;
                end
                APWP_DONE: state_ff <= APWP_IDLE;
                default: state_ff <= APWP_IDLE;
            endcase
        end
    end

    // One start pulse per byte or word cycle
    assign cyc.start = (state_ff == APWP_LOW || state_ff == APWP_HIGH) && !issued_ff;
    assign cyc.isRead = isRead_ff;
    assign cyc.waitStates = 4'(WAIT_STATES);
    assign cmdReady = (state_ff == APWP_IDLE);

    // Read capture, halves assembled low then high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdWord_ff <= 16'h0000;
        end else if (sampleRead) begin
            if (!byteMode_ff) begin
                rdWord_ff <= din_s2_ff;
            end else if (!highHalf_ff) begin
                rdWord_ff[7:0] <= din_s2_ff[7:0];
            end else begin
                rdWord_ff[15:8] <= din_s2_ff[7:0];
            end
        end
    end

    // Response pulse and word, one cycle after the transfer ends
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rspValid_ff <= 1'b0;
            rspData_ff <= 16'h0000;
        end else begin
            rspValid_ff <= (state_ff == APWP_DONE);
            if (state_ff == APWP_DONE) begin
                rspData_ff <= isRead_ff ? rdWord_ff : word_ff;
            end
        end
    end

    assign rspValid = rspValid_ff;
    assign rspData = rspData_ff;
    assign rspResult = rspData_ff[11:0];

    // Pin drive: chip select and strobe asserted together
    assign csN = !strobeActive;
    assign wrN = !(strobeActive && !isRead_ff);
    assign rdN = !(strobeActive && isRead_ff);
    assign wordByteSel = (state_ff == APWP_IDLE) ? wordMode_s2_ff : !byteMode_ff;

    // Data line drive, released during reads except bit 8 in byte mode
    always_comb begin
        dataLinesOut = 16'h0000;
        dataLinesOe = 16'h0000;
        if (dataDrive) begin
            if (!byteMode_ff) begin
                dataLinesOut = word_ff;
                dataLinesOe = 16'hffff;
            end else begin
                dataLinesOut[7:0] = highHalf_ff ? word_ff[15:8] : word_ff[7:0];
                dataLinesOe[7:0] = 8'hff;
            end
        end
        if (byteMode_ff && state_ff != APWP_IDLE) begin
            // Shared pin as high-byte enable
            dataLinesOut[8] = highHalf_ff;
            dataLinesOe[8] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- apwp_host_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module apwp_host_props
    import apwp_pkg::*;
#(
    parameter int WAIT_STATES = 0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Response
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    input wire logic [11:0] rspResult,
    // Device pins
    input wire logic csN,
    input wire logic wrN,
    input wire logic rdN,
    input wire logic wordByteSel,
    input wire logic [15:0] dataLinesOut,
    input wire logic [15:0] dataLinesOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic strb;
    logic [4:0] lowCnt_ff;
    logic [4:0] nxt_lowCnt;
    assign strb = !wrN || !rdN;
    assign nxt_lowCnt = strb ? lowCnt_ff + 5'h01 : 5'h00;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lowCnt_ff <= 5'h00;
        end else begin
            lowCnt_ff <= nxt_lowCnt;
        end
    end
    sequence sLowWr;
        $fell(wrN) && !wordByteSel && !dataLinesOut[8];
    endsequence
    sequence sHighWr;
        $fell(wrN) && dataLinesOut[8];
    endsequence
    a_cs_tracks_strobe: assert property (csN == !strb)
        else $error("chip select not tied to strobes");
    a_one_strobe_only: assert property (!(!wrN && !rdN))
        else $error("read and write strobes low together");
    a_word_write_drive: assert property (!wrN && wordByteSel |-> dataLinesOe == 16'hffff)
        else $error("word write not driving all lines");
    a_byte_sel_drive: assert property (strb && !wordByteSel |-> dataLinesOe[8])
        else $error("byte select line not driven");
    a_read_released: assert property (!rdN |-> dataLinesOe[7:0] == 8'h00)
        else $error("host drives lines during read");
    a_data_steady: assert property (!wrN |=> $stable(dataLinesOut) && dataLinesOe[0])
        else $error("write data moved before hold end");
    a_strobe_width: assert property ($past(strb) && !strb |-> lowCnt_ff == 5'(2 + WAIT_STATES))
        else $error("strobe width wrong");
    a_rsp_pulse: assert property (rspValid |=> !rspValid)
        else $error("response longer than one cycle");
    a_result_field: assert property (rspValid |-> !$past(csN, 3) && rspResult == rspData[11:0])
        else $error("response not after a bus cycle or result field differs");
    a_byte_order: assert property (sLowWr |-> ##[2:40] sHighWr)
        else $error("high byte write did not follow low byte");
endmodule
bind apwp_host apwp_host_props #(.WAIT_STATES(WAIT_STATES)) apwp_host_props_inst (
    .clk(clk), .arst_n(arst_n), .rspValid(rspValid), .rspData(rspData),
    .rspResult(rspResult), .csN(csN), .wrN(wrN), .rdN(rdN), .wordByteSel(wordByteSel),
    .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));
`default_nettype wire

// ---- apwp_host_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module apwp_host_tb_top
    import apwp_pkg::*;
;
    logic clk, arst_n, wordMode, cmdValid, busyPin, cmdReady, rspValid, busyFall;
    logic csN, wrN, rdN, wordByteSel;
    logic [1:0] cmdOp;
    logic [11:0] rspResult, convResult;
    logic [15:0] cmdData, rspData, dataLinesOut, dataLinesOe, devOut, devOe, lastWord;
    logic [15:0] prevBus = 16'h0000;
    wire [15:0] bus;
    int errors, n_tests, cycles, i, k;
    logic [31:0] seed;
    assign bus = (dataLinesOe & dataLinesOut) | (~dataLinesOe & devOe & devOut)
        | (~dataLinesOe & ~devOe & ~prevBus);
    always @(posedge clk) prevBus <= bus;
    apwp_host #(.WAIT_STATES(1)) apwp_host_inst (.clk(clk), .arst_n(arst_n),
        .wordMode(wordMode), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
        .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .rspResult(rspResult),
        .busyPin(busyPin), .busyFall(busyFall), .csN(csN), .wrN(wrN), .rdN(rdN),
        .wordByteSel(wordByteSel), .dataLinesOut(dataLinesOut),
        .dataLinesOe(dataLinesOe), .dataLinesIn(bus));
    apwp_dev_model apwp_dev_model_inst (.csN(csN), .wrN(wrN), .rdN(rdN),
        .wordByteSel(wordByteSel), .bus(bus), .devOut(devOut), .devOe(devOe),
        .convResult(convResult), .lastWord(lastWord));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] expWord(input logic [1:0] op, input logic [15:0] d);
        if (op == 2'h1) begin
            return {4'h0, convResult};
        end
        return (op == 2'h2) ? 16'h0002 : d;
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input logic wm, input logic [1:0] op, input logic [15:0] d);
        logic [3:0] hi0;
        @(negedge clk);
        wordMode = wm;
        seed = xs(seed);
        convResult = seed[11:0];
        repeat (3) @(negedge clk);
        hi0 = apwp_dev_model_inst.hiReads;
        chk("cmdReady", 16'h0001, {15'h0000, cmdReady});
        cmdOp = op;
        cmdData = d;
        cmdValid = 1'b1;
        @(negedge clk);
        cmdValid = 1'b0;
        chk("cmdReadyBusy", 16'h0000, {15'h0000, cmdReady});
        k = 0;
        while (rspValid !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        chk("rspValid", 16'h0001, {15'h0000, rspValid});
        chk("rspData", expWord(op, d), rspData);
        if (op == 2'h1) begin
            chk("rspResult", {4'h0, convResult}, {4'h0, rspResult});
            chk("highReads", {15'h0000, !wm}, {12'h000, 4'(apwp_dev_model_inst.hiReads - hi0)});
        end else begin
            chk("devWord", expWord(op, d), lastWord);
        end
        if (op == 2'h2) begin
            chk("testReg", 16'h0001, {15'h0000, apwp_dev_model_inst.testRegDefault});
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        arst_n = 1'b0;
        wordMode = 1'b1;
        cmdValid = 1'b0;
        cmdOp = 2'h0;
        cmdData = 16'h0000;
        busyPin = 1'b0;
        convResult = 12'h000;
        seed = 32'd46;
        errors = 0;
        n_tests = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        run(1'b0, APWP_OP_WRITE, 16'h01fe);
        run(1'b0, APWP_OP_WRITE, 16'hfe01);
        run(1'b1, APWP_OP_WRITE, 16'h0100);
        run(1'b0, APWP_OP_RECOVER, 16'hffff);
        run(1'b1, APWP_OP_RECOVER, 16'h1234);
        run(1'b0, APWP_OP_READ, 16'h0000);
        for (i = 0; i < 30; i++) begin
            seed = xs(seed);
            run(seed[0], (seed[2:1] == 2'h3) ? 2'h0 : seed[2:1], seed[31:16]);
        end
        @(negedge clk);
        busyPin = 1'b1;
        repeat (5) @(negedge clk);
        busyPin = 1'b0;
        k = 0;
        repeat (8) begin
            @(negedge clk);
            k = k + int'(busyFall === 1'b1);
        end
        chk("busyFall", 16'h0001, 16'(k));
        end_of_test();
    end
endmodule
`default_nettype wire

// ---- apwp_pkg.sv ----
package apwp_pkg;
    typedef enum logic [1:0] {
        APWP_IDLE_ST, APWP_SETUP_ST, APWP_STROBE_ST, APWP_HOLD_ST
    } apwp_phase_type;
    typedef enum logic [1:0] {
        APWP_OP_WRITE, APWP_OP_READ, APWP_OP_RECOVER
    } apwp_op_type;
endpackage
